// File: hw/bus_port_pkg.sv
/*
 * Shared constants for the bus-side reset and pin-ownership port:
 * arbitration slots, control-line bit positions, reset values and the
 * fixed re-drive delay after bus reset release.
 * Assumes one bus clock (sys_clk) and the bus reset presented as rst.
 */
package bus_port_pkg;

    // ============================================================
    // arbitration slots (one-hot positions in the grant vector)
    localparam int NUM_MASTERS   = 6;
    localparam int SLOT_HOST     = 0;
    localparam int SLOT_DEVICE   = 1;
    localparam int SLOT_EXT0     = 2;
    localparam int NUM_EXT       = 4;

    // ============================================================
    // sustained tri-state control lines, bit positions
    localparam int STS_FRAME     = 0;
    localparam int STS_IRDY      = 1;
    localparam int STS_TRDY      = 2;
    localparam int STS_STOP      = 3;
    localparam int STS_DEVSEL    = 4;
    localparam int NUM_STS       = 5;

    // ============================================================
    // reset values
    localparam logic [31:0] AD_RESET_VALUE  = 32'h0000_0000;
    localparam logic [3:0]  CBE_RESET_VALUE = 4'h0;
    localparam logic        PAR_RESET_VALUE = 1'b0;
    localparam logic [5:0]  GRANT_RESET     = 6'h02;

    // ============================================================
    // timing: clock rate and fixed re-drive delay inside the 2..5 window
    localparam int SYS_CLK_MHZ      = 100;
    localparam int REDRIVE_MIN_CLKS = 2;
    localparam int REDRIVE_MAX_CLKS = 5;
    localparam int REDRIVE_CLKS     = 3;

    typedef logic [NUM_MASTERS-1:0] grant_vec_t;

endpackage

// File: hw/bus_port_reset_owner.sv
/*
 * Bus-side reset and pin-ownership logic of a bus-to-legacy bridge.
 * Decides what the bridge drives, floats or releases on the shared
 * address/data, command, parity, control, request and grant lines
 * around bus reset, catches the arbiter strap and runs a small
 * rotating arbiter for six masters.
 * Assumes: sys_clk is the bus clock; rst is bus reset (bus_reset_n
 * inverted, asynchronous); pins arrive unsynchronised; transaction
 * logic of the bridge sits outside and talks through the internal ports.
 */
module bus_port_reset_owner
    import bus_port_pkg::*;
#(
    parameter int REDRIVE = REDRIVE_CLKS
) (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               host_bridge_request_n,
    input  wire logic [NUM_EXT-1:0] master_request_n,
    input  wire logic               frameInN,
    input  wire logic               irdyInN,
    input  wire logic               ownRequest,
    input  wire logic               adDriveReq,
    input  wire logic [31:0]        adData,
    input  wire logic [3:0]         cbeDataN,
    input  wire logic               parData,
    input  wire logic [NUM_STS-1:0] stsOwnReq,
    input  wire logic [NUM_STS-1:0] stsAssert,
    input  wire logic               memoryRequest,
    input  wire logic               flushRequest,
    input  wire logic               wakeRequest,
    output logic [31:0]             adOut,
    output logic                    adOe,
    output logic [3:0]              cbeOutN,
    output logic                    cbeOe,
    output logic                    parOut,
    output logic                    parOe,
    output logic [NUM_STS-1:0]      stsOutN,
    output logic [NUM_STS-1:0]      stsOe,
    output logic                    memory_request_n,
    output logic                    memoryRequestOe,
    output logic                    buffer_flush_request_n,
    output logic                    bufferFlushRequestOe,
    output logic                    host_bridge_grant_n,
    output logic                    hostBridgeGrantOe,
    output logic                    grant0_or_bridge_request_n,
    output logic                    grant0Oe,
    output logic                    grant1_or_wake_n,
    output logic                    grant1Oe,
    output logic [1:0]              extraGrantN,
    output logic                    extraGrantOe,
    output logic                    busGranted,
    output logic                    arbiterEnabled
);

    if (REDRIVE < REDRIVE_MIN_CLKS + 1 || REDRIVE > REDRIVE_MAX_CLKS) begin
        $error("REDRIVE must lie in 3..5 clocks");
    end
    if (SYS_CLK_MHZ <= 0) begin
        $error("clock rate must be positive");
    end

    // ============================================================
    // reset release synchroniser and pin synchronisers
    logic               relSync1_ff;
    logic               busUp_ff;
    logic               hostReqMeta_ff;
    logic               hostReqSyncN_ff;
    logic [NUM_EXT-1:0] mreqMeta_ff;
    logic [NUM_EXT-1:0] mreqSyncN_ff;
    logic [1:0]         idleMeta_ff;
    logic [1:0]         idleSync_ff;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            relSync1_ff <= 1'b0;
            busUp_ff    <= 1'b0;
        end else begin
            relSync1_ff <= 1'b1;
            busUp_ff    <= relSync1_ff;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hostReqMeta_ff  <= 1'b1;
            hostReqSyncN_ff <= 1'b1;
            mreqMeta_ff     <= '1;
            mreqSyncN_ff    <= '1;
            idleMeta_ff     <= 2'h3;
            idleSync_ff     <= 2'h3;
        end else begin
            hostReqMeta_ff  <= host_bridge_request_n;
            hostReqSyncN_ff <= hostReqMeta_ff;
            mreqMeta_ff     <= master_request_n;
            mreqSyncN_ff    <= mreqMeta_ff;
            idleMeta_ff     <= {frameInN, irdyInN};
            idleSync_ff     <= idleMeta_ff;
        end
    end

    // ============================================================
    // release counter, strap capture and park start
    logic [2:0] relCnt_ff;
    logic       strapTaken_ff;
    logic       arbEn_ff;
    logic       parked_ff;
    logic       parkNow;
    logic       arbEnNow;

    // three edges: two synchroniser stages plus one register stage
    assign parkNow  = busUp_ff && !parked_ff && (relCnt_ff == 3'(REDRIVE - 3));
    assign arbEnNow = strapTaken_ff ? arbEn_ff : hostReqSyncN_ff;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            relCnt_ff <= 3'h0;
        end else if (busUp_ff && relCnt_ff != 3'h7) begin
            relCnt_ff <= relCnt_ff + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            strapTaken_ff <= 1'b0;
            arbEn_ff      <= 1'b0;
        end else if (busUp_ff && !strapTaken_ff) begin
            strapTaken_ff <= 1'b1;
            arbEn_ff      <= hostReqSyncN_ff;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            parked_ff <= 1'b0;
        end else if (parkNow) begin
            parked_ff <= 1'b1;
        end
    end

    // ============================================================
    // rotating arbiter over six masters
    grant_vec_t grantVec_ff;
    grant_vec_t reqVec;
    grant_vec_t nxt_grantVec;
    logic       busIdle;

    assign reqVec  = {~mreqSyncN_ff, ownRequest, ~hostReqSyncN_ff};
    assign busIdle = &idleSync_ff;

    function automatic grant_vec_t pickNext(input grant_vec_t req,
                                            input grant_vec_t cur);
        int         pos;
        int         idx;
        grant_vec_t res;
        pos = 0;
        res = cur;
        for (int i = 0; i < NUM_MASTERS; i++) begin
            if (cur[i])
                pos = i;
        end
        for (int k = NUM_MASTERS; k >= 1; k--) begin
            idx = (pos + k) % NUM_MASTERS;
            if (req[idx])
                res = grant_vec_t'(1) << idx;
        end
        return res;
    endfunction

    always_comb begin
        nxt_grantVec = grantVec_ff;
        // regrant only on an idle bus once the current owner lets go
        if (arbEn_ff && parked_ff && busIdle && !(|(reqVec & grantVec_ff)) && |reqVec)
            nxt_grantVec = pickNext(reqVec, grantVec_ff);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            grantVec_ff <= GRANT_RESET;
        end else begin
            grantVec_ff <= nxt_grantVec;
        end
    end

    // ============================================================
    // address/data, command and parity ownership
    logic devHolds;
    assign devHolds = arbEnNow && (parkNow || (parked_ff && nxt_grantVec[SLOT_DEVICE]));

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            adOe    <= 1'b1;
            cbeOe   <= 1'b1;
            parOe   <= 1'b1;
            adOut   <= AD_RESET_VALUE;
            cbeOutN <= CBE_RESET_VALUE;
            parOut  <= PAR_RESET_VALUE;
        end else if (!busUp_ff) begin
            adOe    <= 1'b0;
            cbeOe   <= 1'b0;
            parOe   <= 1'b0;
            adOut   <= AD_RESET_VALUE;
            cbeOutN <= CBE_RESET_VALUE;
            parOut  <= PAR_RESET_VALUE;
        end else begin
            // off arbiter: only a real transaction drives the lines
            adOe    <= adDriveReq || devHolds;
            cbeOe   <= adDriveReq || devHolds;
            parOe   <= adDriveReq || devHolds;
            adOut   <= adDriveReq ? adData : AD_RESET_VALUE;
            cbeOutN <= adDriveReq ? cbeDataN : CBE_RESET_VALUE;
            parOut  <= adDriveReq ? parData : PAR_RESET_VALUE;
        end
    end

    // ============================================================
    // sustained tri-state control lines
    logic [NUM_STS-1:0] stsWait_ff;
    logic [NUM_STS-1:0] stsOwn_ff;
    logic [NUM_STS-1:0] stsPark_ff;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stsWait_ff <= '0;
            stsOwn_ff  <= '0;
            stsPark_ff <= '0;
            stsOe      <= '0;
            stsOutN    <= '1;
        end else begin
            for (int i = 0; i < NUM_STS; i++) begin
                if (!busUp_ff) begin
                    stsWait_ff[i] <= 1'b0;
                end else if (stsPark_ff[i]) begin
                    stsPark_ff[i] <= 1'b0;
                    stsOwn_ff[i]  <= 1'b0;
                    stsOe[i]      <= 1'b0;
                end else if (stsOwn_ff[i] && stsOwnReq[i]) begin
                    stsOutN[i]    <= ~stsAssert[i];
                end else if (stsOwn_ff[i]) begin
                    stsOutN[i]    <= 1'b1;
                    stsPark_ff[i] <= 1'b1;
                end else if (stsWait_ff[i]) begin
                    // one clock of turnaround before taking the line
                    stsWait_ff[i] <= 1'b0;
                    stsOwn_ff[i]  <= stsOwnReq[i];
                    stsOe[i]      <= stsOwnReq[i];
                    stsOutN[i]    <= ~(stsOwnReq[i] && stsAssert[i]);
                end else if (stsOwnReq[i]) begin
                    stsWait_ff[i] <= 1'b1;
                end
            end
        end
    end

    // ============================================================
    // memory and flush requests
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            memoryRequestOe        <= 1'b0;
            bufferFlushRequestOe   <= 1'b0;
            memory_request_n       <= 1'b1;
            buffer_flush_request_n <= 1'b1;
        end else begin
            // first edge after release, before the synchroniser settles
            memoryRequestOe        <= 1'b1;
            bufferFlushRequestOe   <= 1'b1;
            memory_request_n       <= ~(busUp_ff && memoryRequest);
            buffer_flush_request_n <= ~(busUp_ff && flushRequest);
        end
    end

    // ============================================================
    // grant lines, bridge request and wake
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hostBridgeGrantOe          <= 1'b0;
            grant0Oe                   <= 1'b0;
            grant1Oe                   <= 1'b0;
            extraGrantOe               <= 1'b0;
            host_bridge_grant_n        <= 1'b1;
            grant0_or_bridge_request_n <= 1'b1;
            grant1_or_wake_n           <= 1'b1;
            extraGrantN                <= 2'h3;
            busGranted                 <= 1'b0;
            arbiterEnabled             <= 1'b0;
        end else begin
            hostBridgeGrantOe <= busUp_ff;
            grant0Oe          <= busUp_ff;
            grant1Oe          <= busUp_ff;
            extraGrantOe      <= busUp_ff && arbEnNow;
            arbiterEnabled    <= arbEnNow;
            if (busUp_ff && arbEnNow && parked_ff) begin
                host_bridge_grant_n        <= ~nxt_grantVec[SLOT_HOST];
                grant0_or_bridge_request_n <= ~nxt_grantVec[SLOT_EXT0];
                grant1_or_wake_n           <= ~nxt_grantVec[SLOT_EXT0 + 1];
                extraGrantN                <= ~nxt_grantVec[SLOT_EXT0 + 3:SLOT_EXT0 + 2];
                busGranted                 <= nxt_grantVec[SLOT_DEVICE];
            end else if (busUp_ff && !arbEnNow) begin
                // shared pins turn into request and wake for an outside arbiter
                host_bridge_grant_n        <= 1'b1;
                grant0_or_bridge_request_n <= ~ownRequest;
                grant1_or_wake_n           <= ~wakeRequest;
                extraGrantN                <= 2'h3;
                busGranted                 <= 1'b0;
            end else begin
                host_bridge_grant_n        <= 1'b1;
                grant0_or_bridge_request_n <= 1'b1;
                grant1_or_wake_n           <= 1'b1;
                extraGrantN                <= 2'h3;
                busGranted                 <= parkNow;
            end
        end
    end

endmodule

// File: testbench/bus_master_model.sv
/*
 * Model of the host bridge and four external bus masters.
 * Assumes grants arrive active low and already gated by their enables.
 */
module bus_master_model
    import bus_port_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               quiet,
    input  wire logic               strap,
    input  wire logic [NUM_EXT-1:0] reqWish,
    input  wire logic [NUM_EXT-1:0] grantN,
    output logic                    host_bridge_request_n,
    output logic [NUM_EXT-1:0]      master_request_n,
    output logic                    frameInN,
    output logic                    irdyInN
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] busy_ff;
    // host never asks after reset, so its pin holds the strap level
    assign host_bridge_request_n = strap;
    // ready follows frame; both rest at the pull-up level once released
    assign irdyInN = frameInN;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            master_request_n <= #1 '1;
            busy_ff <= #1 3'h0;
            frameInN <= #1 1'b1;
        end else if (busy_ff != 3'h0) begin
            busy_ff <= #1 busy_ff - 3'h1;
            // one driven-high clock before letting go
            frameInN <= #1 (busy_ff <= 3'h2);
            if (busy_ff == 3'h1)
                master_request_n <= #1 master_request_n | ~grantN;
        end else begin
            master_request_n <= #1 master_request_n & ~(reqWish & {NUM_EXT{~quiet}});
            // start a clock after grant and idle bus are seen
            if ((~master_request_n & ~grantN) != '0 && frameInN)
                busy_ff <= #1 3'h5;
        end
    end
endmodule

// File: testbench/bus_port_chk.sv
/*
 * Checker for the bus reset and pin-ownership port.
 * Assumes sys_clk is the bus clock and rst the active-high bus reset.
 */
module bus_port_chk
    import bus_port_pkg::*;
#(
    parameter int REDRIVE = REDRIVE_CLKS
) (
    input wire logic               sys_clk,
    input wire logic               rst,
    input wire logic [NUM_EXT-1:0] master_request_n,
    input wire logic [NUM_STS-1:0] stsOwnReq,
    input wire logic               memoryRequest,
    input wire logic [31:0]        adOut,
    input wire logic               adOe,
    input wire logic               cbeOe,
    input wire logic               parOe,
    input wire logic [NUM_STS-1:0] stsOutN,
    input wire logic [NUM_STS-1:0] stsOe,
    input wire logic               memory_request_n,
    input wire logic               memoryRequestOe,
    input wire logic               host_bridge_grant_n,
    input wire logic               grant0_or_bridge_request_n,
    input wire logic               grant0Oe,
    input wire logic               busGranted,
    input wire logic               arbiterEnabled
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ============================================================
    // clocks since release; saturates so late traffic is not aliased
    logic [3:0] relCnt_ff;
    always_ff @(posedge sys_clk or posedge rst)
        if (rst)
            relCnt_ff <= 4'h0;
        else if (relCnt_ff != 4'hF)
            relCnt_ff <= relCnt_ff + 4'h1;

    sequence ctlGrab;
        $rose(stsOwnReq[0]) && !stsOe[0];
    endsequence
    sequence ctlDrop;
        $fell(stsOwnReq[0]) && stsOe[0];
    endsequence

    a_reset_drive_low: assert property (disable iff (1'b0)
        rst |-> adOe && cbeOe && parOe && adOut == 32'h0000_0000)
        else $error("bus lines not driven low in reset");
    a_reset_float_ctl: assert property (disable iff (1'b0)
        rst |-> stsOe == '0 && !memoryRequestOe && !grant0Oe)
        else $error("control lines driven in reset");
    a_release_float_ad: assert property (relCnt_ff >= 4'h1 && relCnt_ff < REDRIVE
        |-> !adOe && !cbeOe && !parOe)
        else $error("bus lines not floated after release");
    a_redrive_park: assert property (relCnt_ff == REDRIVE
        |-> adOe == arbiterEnabled && busGranted == arbiterEnabled)
        else $error("re-drive does not follow strap");
    a_mem_follow: assert property (relCnt_ff >= 4'h4
        |=> memory_request_n == !$past(memoryRequest))
        else $error("memory request not passed on");
    a_ctl_turnaround: assert property (ctlGrab |=> !stsOe[0] ##1 stsOe[0])
        else $error("control line turnaround wrong");
    a_ctl_release: assert property (ctlDrop
        |=> (stsOe[0] && stsOutN[0]) ##1 !stsOe[0])
        else $error("control line not driven high before float");
    a_grant_exclusive: assert property (arbiterEnabled
        |-> $countones({~host_bridge_grant_n, ~grant0_or_bridge_request_n, busGranted}) <= 1)
        else $error("more than one grant");
    a_grant_needs_req: assert property ($fell(grant0_or_bridge_request_n) && arbiterEnabled
        |-> !$past(master_request_n[0], 2))
        else $error("grant without request");
endmodule

bind bus_port_reset_owner bus_port_chk #(.REDRIVE(REDRIVE)) chk_i (
    .sys_clk, .rst, .master_request_n, .stsOwnReq, .memoryRequest, .adOut, .adOe, .cbeOe,
    .parOe, .stsOutN, .stsOe, .memory_request_n, .memoryRequestOe, .host_bridge_grant_n,
    .grant0_or_bridge_request_n, .grant0Oe, .busGranted, .arbiterEnabled
);

// File: testbench/tb.sv
/*
 * Self-checking bench for the bus reset and pin-ownership port.
 * Assumes package, port module, master model and checker are compiled first.
 */
module tb
    import bus_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RD = 4;
    logic sys_clk, rst, strap, quiet, ownRequest, adDriveReq, parData, parOut;
    logic memoryRequest, flushRequest, wakeRequest, host_bridge_request_n, frameInN, irdyInN;
    logic adOe, cbeOe, parOe, memory_request_n, memoryRequestOe, buffer_flush_request_n;
    logic bufferFlushRequestOe, host_bridge_grant_n, hostBridgeGrantOe;
    logic grant0_or_bridge_request_n, grant0Oe, grant1_or_wake_n, grant1Oe, extraGrantOe;
    logic busGranted, arbiterEnabled;
    logic [31:0] adData, adOut;
    logic [3:0] cbeDataN, cbeOutN;
    logic [1:0] extraGrantN;
    logic [NUM_EXT-1:0] master_request_n, reqWish, grantN;
    logic [NUM_STS-1:0] stsOwnReq, stsAssert, stsOutN, stsOe;
    integer errors, nChecks, seed, cycles, k, got;

    assign grantN = {extraGrantN | {2{~extraGrantOe}}, grant1_or_wake_n | ~grant1Oe,
                     grant0_or_bridge_request_n | ~grant0Oe};

    bus_port_reset_owner #(.REDRIVE(RD)) uut (
        .sys_clk, .rst, .host_bridge_request_n, .master_request_n, .frameInN, .irdyInN,
        .ownRequest, .adDriveReq, .adData, .cbeDataN, .parData, .stsOwnReq, .stsAssert,
        .memoryRequest, .flushRequest, .wakeRequest, .adOut, .adOe, .cbeOutN, .cbeOe,
        .parOut, .parOe, .stsOutN, .stsOe, .memory_request_n, .memoryRequestOe,
        .buffer_flush_request_n, .bufferFlushRequestOe, .host_bridge_grant_n,
        .hostBridgeGrantOe, .grant0_or_bridge_request_n, .grant0Oe, .grant1_or_wake_n,
        .grant1Oe, .extraGrantN, .extraGrantOe, .busGranted, .arbiterEnabled
    );
    bus_master_model partner (
        .sys_clk, .rst, .quiet, .strap, .reqWish, .grantN, .host_bridge_request_n,
        .master_request_n, .frameInN, .irdyInN
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ============================================================
    // hang guard, well above the roughly 590 clocks the run needs
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            errors = errors + 1;
            testDone();
        end
    end

    task automatic testDone();
        if (errors == 0 && nChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [63:0] gotVal, input logic [63:0] expVal);
        nChecks = nChecks + 1;
        if (gotVal !== expVal) begin
            errors = errors + 1;
            $display("FAIL %0t got %h expected %h", $time, gotVal, expVal);
        end
    endtask

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    function automatic logic [63:0] expAd(int j, logic s);
        return (s && j >= RD) ? 64'h7 : 64'h0;
    endfunction

    // reset lands and lifts mid-cycle, so neither reset edge is aligned to the clock
    task automatic doReset(input logic s, input int len);
        int j;
        quiet = 1'b1;
        strap = s;
        #3;
        rst = 1'b1;
        #1;
        chk(64'({adOe, cbeOe, parOe, adOut, cbeOutN, parOut}), 64'h0000_00E0_0000_0000);
        chk(64'({stsOe, memoryRequestOe, bufferFlushRequestOe}), 64'h0);
        chk(64'({hostBridgeGrantOe, grant0Oe, grant1Oe, extraGrantOe, busGranted}), 64'h0);
        repeat (len) @(posedge sys_clk);
        #4;
        rst = 1'b0;
        for (j = 1; j <= RD + 1; j++) begin
            tick();
            chk(64'({adOe, cbeOe, parOe}), expAd(j, s));
            if (j == 1)
                chk(64'({memoryRequestOe, memory_request_n, bufferFlushRequestOe}), 64'h7);
            if (j >= 3)
                chk(64'(arbiterEnabled), 64'(s));
        end
    endtask

    initial begin
        {errors, nChecks, cycles} = '0;
        seed = 40451;
        rst = 1'b1;
        {ownRequest, adDriveReq, parData, memoryRequest, flushRequest, wakeRequest} = '0;
        {adData, cbeDataN, stsOwnReq, stsAssert, reqWish} = '0;
        doReset(1'b1, 8);
        for (k = 0; k < NUM_STS; k++) begin
            stsAssert = '1;
            stsOwnReq[k] = 1'b1;
            tick();
            chk(64'(stsOe), 64'h0);
            tick();
            chk(64'({stsOe, stsOutN[k]}), 64'(1) << (k + 1));
            stsOwnReq[k] = 1'b0;
            tick();
            chk(64'({stsOe[k], stsOutN[k]}), 64'h3);
            tick();
            chk(64'(stsOe), 64'h0);
        end
        for (k = 0; k < 12; k++) begin
            adDriveReq = 1'($random(seed));
            adData = $random(seed);
            cbeDataN = 4'($random(seed));
            parData = 1'($random(seed));
            memoryRequest = 1'($random(seed));
            flushRequest = 1'($random(seed));
            tick();
            chk(64'({adOe, adOut, cbeOutN, parOut}),
                64'({1'b1, adDriveReq ? {adData, cbeDataN, parData} : 37'h0}));
            chk(64'({memory_request_n, buffer_flush_request_n}),
                64'({~memoryRequest, ~flushRequest}));
        end
        adDriveReq = 1'b0;
        quiet = 1'b0;
        got = 0;
        for (k = 0; k < 300; k++) begin
            reqWish = 4'($random(seed));
            tick();
            chk(64'($countones({~grantN, ~host_bridge_grant_n, busGranted}) <= 1), 64'h1);
            if (grantN != 4'hF) begin
                got = got + 1;
                chk(64'({adOe, busGranted}), 64'h0);
            end
        end
        chk(64'(got > 0), 64'h1);
        doReset(1'b0, 110);
        for (k = 0; k < 10; k++) begin
            ownRequest = 1'($random(seed));
            wakeRequest = 1'($random(seed));
            tick();
            chk(64'({grant0_or_bridge_request_n, grant1_or_wake_n, adOe, extraGrantOe}),
                64'({~ownRequest, ~wakeRequest, 2'b00}));
        end
        doReset(1'b1, 110);
        testDone();
    end
endmodule
